// [anpr_pkg.sv]
// Constants and carriers for the auto-negotiation page register group.
// Assumes a management front end that presents one 16-bit register access.
package anpr_pkg;
  // Register addresses on the management bus (5-bit register field)
  localparam logic [4:0] ANPR_ADDR_BASE_ABILITY = 5'h05;
  localparam logic [4:0] ANPR_ADDR_EXPANSION    = 5'h06;
  localparam logic [4:0] ANPR_ADDR_NP_TRANSMIT  = 5'h07;
  localparam logic [4:0] ANPR_ADDR_NP_RECEIVE   = 5'h08;
  // Reset values
  localparam logic [15:0] ANPR_RST_BASE_ABILITY = 16'h0000;
  localparam logic [15:0] ANPR_RST_NP_RECEIVE   = 16'h0000;
  localparam logic [10:0] ANPR_RST_NP_MESSAGE   = 11'h001;
  localparam logic        ANPR_RST_NP_MSG_PAGE  = 1'b1;
  localparam logic        ANPR_RST_NP_ACK2      = 1'b0;
  localparam logic        ANPR_RST_NP_NEXT      = 1'b0;
  localparam logic        ANPR_RST_NP_TOGGLE    = 1'b0;
  localparam logic        ANPR_RST_LOCAL_NP_HW  = 1'b1;
  localparam logic        ANPR_RST_LOCAL_NP_SW  = 1'b0;
  // Code word field positions
  localparam int ANPR_POS_MSG_HI    = 10;
  localparam int ANPR_POS_TOGGLE    = 11;
  localparam int ANPR_POS_ACK2      = 12;
  localparam int ANPR_POS_MSG_PAGE  = 13;
  localparam int ANPR_POS_ACK       = 14;
  localparam int ANPR_POS_NEXT_PAGE = 15;
  // Expansion register field positions
  localparam int ANPR_POS_LP_AN_ABLE  = 0;
  localparam int ANPR_POS_PAGE_RCVD   = 1;
  localparam int ANPR_POS_LOCAL_NP    = 2;
  localparam int ANPR_POS_LP_NP_ABLE  = 3;
  localparam int ANPR_POS_PD_FAULT    = 4;

  // One management access, already deserialised
  typedef struct packed {
    logic        rd;     // Read strobe, one cycle
    logic        wr;     // Write strobe, one cycle
    logic [4:0]  addr;   // Register address
    logic [15:0] wdata;  // Write data
  } anpr_mgmt_req_t;

  // Page event from the arbitration engine
  typedef struct packed {
    logic        valid;  // One-cycle page strobe
    logic        base;   // 1: base page, 0: next page
    logic [15:0] word;   // Complete received code word
  } anpr_page_t;
endpackage

// [anpr_page_capture.sv]
// Captures one complete received code word into a held register.
// Assumes the word is stable in the cycle that its strobe is high.
`timescale 1ns/10ps
module anpr_page_capture
  import anpr_pkg::*;
#(
  parameter int          WIDTH     = 16,
  parameter logic [15:0] RST_VALUE = 16'h0000
) (
  input  wire logic             clk_i,      // System clock
  input  wire logic             rst_n_i,    // Synchronised reset, low
  input  wire logic             soft_rst_i, // Software reset pulse
  input  wire logic             load_i,     // Capture strobe
  input  wire logic [WIDTH-1:0] word_i,     // Word to capture
  output logic      [WIDTH-1:0] held_o      // Held copy
);
  logic [WIDTH-1:0] held_reg;   // Stored page
  logic [WIDTH-1:0] held_next;  // Next stored page

  // Whole word replaced at once, never field by field
  always_comb begin
    held_next = held_reg;
    if (soft_rst_i) begin
      held_next = RST_VALUE[WIDTH-1:0];
    end else if (load_i) begin
      held_next = word_i;
    end
  end

  // Register only
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      held_reg <= RST_VALUE[WIDTH-1:0];
    end else begin
      held_reg <= held_next;
    end
  end

  assign held_o = held_reg;
endmodule

// [anpr_regs.sv]
// Auto-negotiation page register group: partner base page, expansion,
// next page transmit and partner next page receive.
// Assumes a management front end delivering single-cycle accesses and an
// arbitration engine that strobes complete pages and takes tx words.
//
// Contract
// - 5.5 shows partner 10BASE-T half duplex
// - 5.6 shows partner 10BASE-T full duplex
// - 5.7/5.8 show partner 100BASE-TX half/full
// - 5.9 shows partner 100BASE-T4 ability
// - 5.10 shows partner symmetric pause
// - 5.11 shows partner asymmetric pause
// - 5.13 copies received remote fault bit
// - 5.14 copies received acknowledge bit
// - 5.15 copies received next page bit
// - 6.0 shows partner negotiation able
// - 6.1 page received latches until read
// - 6.2 local next page: hw 1, sw 0
// - 6.3 shows partner next page able
// - 6.4 parallel fault; 15:5 read zero
// - Writable message field sent, resets 0x001
// - Toggle bit kept by device, read-only
// - 7.12 writable acknowledge-2 sent as bit 12
// - Message page writable, defaults to one
// - 7.14 reserved, sent as zero
// - 7.15 writable next page flag sent
// - Received message field shown read-only
// - Received toggle, ack2, mp, ack shown
// - 8.15 shows received next page flag
`timescale 1ns/10ps
module anpr_regs
  import anpr_pkg::*;
#(
  parameter int DATA_W = 16   // Register width
) (
  input  wire logic              ref_clk_i,      // 125 MHz clock
  input  wire logic              arst_n_i,       // Async reset, low
  input  wire logic              soft_rst_i,     // Software reset pulse
  input  wire anpr_mgmt_req_t    mgmt_req_i,     // Management access
  output logic      [DATA_W-1:0] mgmt_rdata_o,   // Read data, registered
  output logic                   mgmt_rvalid_o,  // Read data valid pulse
  input  wire anpr_page_t        page_i,         // Received page strobe
  input  wire logic              lp_an_able_i,   // Partner negotiates
  input  wire logic              pd_fault_i,     // Parallel detect fault
  input  wire logic              np_sent_i,      // Tx next page taken
  output logic      [DATA_W-1:0] tx_word_o       // Next page tx word
);
  // Reset release
  // Only the assertion of the pin reset may be asynchronous: a release
  // near a clock edge would let some flops leave reset a cycle before
  // others, so the release passes two stages first.
  logic rst_meta_reg;  // First synchroniser stage
  logic rst_n;         // Synchronised reset

  // Assert immediately, release after two edges
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // Decoded access strobes
  // One access per strobe, so a plain address compare is enough;
  // the bus has no write mask and no byte lanes.
  function automatic logic hit(input anpr_mgmt_req_t r,
                               input logic [4:0] a);
    hit = (r.addr == a);
  endfunction

  logic rd_exp;   // Read of expansion register
  logic wr_ntx;   // Write of next page transmit
  assign rd_exp = mgmt_req_i.rd && hit(mgmt_req_i, ANPR_ADDR_EXPANSION);
  assign wr_ntx = mgmt_req_i.wr && hit(mgmt_req_i, ANPR_ADDR_NP_TRANSMIT);

  // Received page holders, whole-word capture
  // Both page kinds share one word bus; the base flag steers the strobe.
  // Each holder swaps its whole word at one edge, so a read never sees
  // half of an old page and half of a new one.
  logic [15:0] base_held;  // Partner base page
  logic [15:0] np_held;    // Partner next page
  logic        load_base;  // Base page strobe
  logic        load_np;    // Next page strobe
  assign load_base = page_i.valid && page_i.base;
  assign load_np   = page_i.valid && !page_i.base;

  anpr_page_capture #(
    .WIDTH     (16),
    .RST_VALUE (ANPR_RST_BASE_ABILITY)
  ) u_base_cap (
    .clk_i      (ref_clk_i),
    .rst_n_i    (rst_n),
    .soft_rst_i (soft_rst_i),
    .load_i     (load_base),
    .word_i     (page_i.word),
    .held_o     (base_held)
  );

  anpr_page_capture #(
    .WIDTH     (16),
    .RST_VALUE (ANPR_RST_NP_RECEIVE)
  ) u_np_cap (
    .clk_i      (ref_clk_i),
    .rst_n_i    (rst_n),
    .soft_rst_i (soft_rst_i),
    .load_i     (load_np),
    .word_i     (page_i.word),
    .held_o     (np_held)
  );

  // Expansion and transmit state
  // Live status inputs pass through one flop, so a read sees a value
  // that stood for a whole cycle; the page flag is the only latching bit.
  // Toggle belongs to the device: writes to bits 11 and 14 fall away.
  logic        page_rcvd_reg;    // Latched page received
  logic        page_rcvd_next;
  logic        local_np_reg;     // Local next page able
  logic        local_np_next;
  logic        lp_an_reg;        // Partner negotiation able
  logic        lp_an_next;
  logic        pd_fault_reg;     // Parallel detection fault
  logic        pd_fault_next;
  logic [10:0] np_msg_reg;       // Tx message field
  logic [10:0] np_msg_next;
  logic        np_toggle_reg;    // Tx toggle
  logic        np_toggle_next;
  logic        np_ack2_reg;      // Tx acknowledge 2
  logic        np_ack2_next;
  logic        np_mp_reg;        // Tx message page
  logic        np_mp_next;
  logic        np_next_reg;      // Tx next page flag
  logic        np_next_next;

  // Next values for status and transmit fields
  always_comb begin
    page_rcvd_next = page_rcvd_reg;
    local_np_next  = local_np_reg;
    lp_an_next     = lp_an_able_i;
    pd_fault_next  = pd_fault_i;
    np_msg_next    = np_msg_reg;
    np_toggle_next = np_toggle_reg;
    np_ack2_next   = np_ack2_reg;
    np_mp_next     = np_mp_reg;
    np_next_next   = np_next_reg;
    if (soft_rst_i) begin
      // Software reset: local next page drops to its soft value
      page_rcvd_next = 1'b0;
      local_np_next  = ANPR_RST_LOCAL_NP_SW;
      lp_an_next     = 1'b0;
      pd_fault_next  = 1'b0;
      np_msg_next    = ANPR_RST_NP_MESSAGE;
      np_toggle_next = ANPR_RST_NP_TOGGLE;
      np_ack2_next   = ANPR_RST_NP_ACK2;
      np_mp_next     = ANPR_RST_NP_MSG_PAGE;
      np_next_next   = ANPR_RST_NP_NEXT;
    end else begin
      // Read clears the latch; a page in the same cycle wins
      if (rd_exp) begin
        page_rcvd_next = 1'b0;
      end
      if (page_i.valid) begin
        page_rcvd_next = 1'b1;
      end
      // Writable fields; toggle and bit 14 ignore writes
      if (wr_ntx) begin
        np_msg_next  = mgmt_req_i.wdata[ANPR_POS_MSG_HI:0];
        np_ack2_next = mgmt_req_i.wdata[ANPR_POS_ACK2];
        np_mp_next   = mgmt_req_i.wdata[ANPR_POS_MSG_PAGE];
        np_next_next = mgmt_req_i.wdata[ANPR_POS_NEXT_PAGE];
      end
      // Toggle flips after each next page the engine sends
      if (np_sent_i) begin
        np_toggle_next = !np_toggle_reg;
      end
    end
  end

  // Register only
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      page_rcvd_reg <= 1'b0;
      local_np_reg  <= ANPR_RST_LOCAL_NP_HW;
      lp_an_reg     <= 1'b0;
      pd_fault_reg  <= 1'b0;
      np_msg_reg    <= ANPR_RST_NP_MESSAGE;
      np_toggle_reg <= ANPR_RST_NP_TOGGLE;
      np_ack2_reg   <= ANPR_RST_NP_ACK2;
      np_mp_reg     <= ANPR_RST_NP_MSG_PAGE;
      np_next_reg   <= ANPR_RST_NP_NEXT;
    end else begin
      page_rcvd_reg <= page_rcvd_next;
      local_np_reg  <= local_np_next;
      lp_an_reg     <= lp_an_next;
      pd_fault_reg  <= pd_fault_next;
      np_msg_reg    <= np_msg_next;
      np_toggle_reg <= np_toggle_next;
      np_ack2_reg   <= np_ack2_next;
      np_mp_reg     <= np_mp_next;
      np_next_reg   <= np_next_next;
    end
  end

  // Register images
  // Built from held state only, never from the live page bus, so a page
  // that arrives together with a read cannot tear the returned word.
  logic [15:0] base_img;  // Partner base ability image
  logic [15:0] exp_img;   // Expansion image
  logic [15:0] ntx_img;   // Next page transmit image

  // Base image: a straight copy of the received word, except bit 12, which reads zero
  always_comb begin
    base_img     = 16'h0000;
    base_img[4:0] = base_held[4:0];    // Selector field
    base_img[5]  = base_held[5];
    base_img[6]  = base_held[6];
    base_img[7]  = base_held[7];
    base_img[8]  = base_held[8];
    base_img[9]  = base_held[9];
    base_img[10] = base_held[10];
    base_img[11] = base_held[11];
    base_img[13] = base_held[13];
    base_img[14] = base_held[14];
    base_img[15] = base_held[15];
  end

  // Expansion image; upper bits reserved as zero
  always_comb begin
    exp_img = 16'h0000;
    exp_img[ANPR_POS_LP_AN_ABLE] = lp_an_reg;
    exp_img[ANPR_POS_PAGE_RCVD]  = page_rcvd_reg;
    exp_img[ANPR_POS_LOCAL_NP]   = local_np_reg;
    exp_img[ANPR_POS_LP_NP_ABLE] = base_held[15];
    exp_img[ANPR_POS_PD_FAULT]   = pd_fault_reg;
  end

  // Transmit word image; bit 14 stays zero
  always_comb begin
    ntx_img = 16'h0000;
    ntx_img[ANPR_POS_MSG_HI:0]     = np_msg_reg;
    ntx_img[ANPR_POS_TOGGLE]       = np_toggle_reg;
    ntx_img[ANPR_POS_ACK2]         = np_ack2_reg;
    ntx_img[ANPR_POS_MSG_PAGE]     = np_mp_reg;
    ntx_img[ANPR_POS_NEXT_PAGE]    = np_next_reg;
  end

  assign tx_word_o = ntx_img[DATA_W-1:0];

  // Read data, registered one cycle after the strobe
  // An expansion read clears the page flag at the edge that captures its
  // image, so that read still returns the set value; the next read shows
  // the cleared one. Writes never disturb this path.
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic        rvalid_reg;
  logic        rvalid_next;

  // Address decode; unmapped addresses read zero
  always_comb begin
    rvalid_next = mgmt_req_i.rd;
    rdata_next  = rdata_reg;
    if (mgmt_req_i.rd) begin
      if (mgmt_req_i.addr == ANPR_ADDR_BASE_ABILITY) begin
        rdata_next = base_img;
      end else if (mgmt_req_i.addr == ANPR_ADDR_EXPANSION) begin
        rdata_next = exp_img;   // Value before the clear
      end else if (mgmt_req_i.addr == ANPR_ADDR_NP_TRANSMIT) begin
        rdata_next = ntx_img;
      end else if (mgmt_req_i.addr == ANPR_ADDR_NP_RECEIVE) begin
        rdata_next = np_held;
      end else begin
        rdata_next = 16'h0000;
      end
    end
  end

  // Register only
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg  <= 16'h0000;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign mgmt_rdata_o  = rdata_reg[DATA_W-1:0];
  assign mgmt_rvalid_o = rvalid_reg;
endmodule

// [anpr_regs_checker.sv]
// Assertion checker for the auto-negotiation page register group.
// Assumes it is bound to anpr_regs and sees only the top module ports.
`timescale 1ns/10ps
module anpr_regs_checker
  import anpr_pkg::*;
#(
  parameter int DATA_W = 16  // Register width
) (
  input wire logic              ref_clk_i,
  input wire logic              arst_n_i,
  input wire logic              soft_rst_i,
  input wire anpr_mgmt_req_t    mgmt_req_i,
  input wire logic [DATA_W-1:0] mgmt_rdata_o,
  input wire logic              mgmt_rvalid_o,
  input wire anpr_page_t        page_i,
  input wire logic              lp_an_able_i,
  input wire logic              pd_fault_i,
  input wire logic              np_sent_i,
  input wire logic [DATA_W-1:0] tx_word_o
);
  // Single domain, so one clock and one disable for all
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);

  AST_READ_ANSWER: assert property (mgmt_req_i.rd |=> mgmt_rvalid_o)
    else $error("read not answered next cycle");
  AST_TX_RESERVED: assert property (tx_word_o[14] == 1'b0)
    else $error("tx word bit 14 not zero");
  AST_TX_WRITE: assert property (
    mgmt_req_i.wr && mgmt_req_i.addr == ANPR_ADDR_NP_TRANSMIT && !soft_rst_i
    |=> tx_word_o[10:0] == $past(mgmt_req_i.wdata[10:0])
    && tx_word_o[15:12] == {$past(mgmt_req_i.wdata[15]), 1'b0,
                            $past(mgmt_req_i.wdata[13:12])})
    else $error("tx word does not follow write");
  AST_TOGGLE_FLIP: assert property (
    np_sent_i && !soft_rst_i |=> tx_word_o[11] != $past(tx_word_o[11]))
    else $error("toggle did not flip");
  AST_TOGGLE_HOLD: assert property (
    !np_sent_i && !soft_rst_i |=> $stable(tx_word_o[11]))
    else $error("toggle moved without a sent page");
  AST_SOFT_DEFAULT: assert property (
    soft_rst_i |=> tx_word_o == 16'h2001)
    else $error("tx word default wrong after soft reset");
  AST_BASE_READ: assert property (
    page_i.valid && page_i.base && !soft_rst_i ##1 mgmt_req_i.rd
    && mgmt_req_i.addr == ANPR_ADDR_BASE_ABILITY && !page_i.valid
    && !soft_rst_i |=> mgmt_rdata_o == ($past(page_i.word, 2) & 16'hEFFF))
    else $error("base page read differs from received word");
  AST_NP_READ: assert property (
    page_i.valid && !page_i.base && !soft_rst_i ##1 mgmt_req_i.rd
    && mgmt_req_i.addr == ANPR_ADDR_NP_RECEIVE && !page_i.valid
    && !soft_rst_i |=> mgmt_rdata_o == $past(page_i.word, 2))
    else $error("next page read differs from received word");
  AST_PAGE_LATCH: assert property (
    page_i.valid && !soft_rst_i ##1 mgmt_req_i.rd && !soft_rst_i
    && mgmt_req_i.addr == ANPR_ADDR_EXPANSION |=> mgmt_rdata_o[1])
    else $error("page received flag not set");
  AST_EXP_CLEAR: assert property (
    mgmt_req_i.rd && mgmt_req_i.addr == ANPR_ADDR_EXPANSION && !page_i.valid
    ##1 (!page_i.valid && !soft_rst_i)[*2] ##0 mgmt_req_i.rd
    && mgmt_req_i.addr == ANPR_ADDR_EXPANSION |=> !mgmt_rdata_o[1])
    else $error("page received flag not cleared by read");
  AST_SET_WINS: assert property (
    mgmt_req_i.rd && mgmt_req_i.addr == ANPR_ADDR_EXPANSION && page_i.valid
    && !soft_rst_i ##1 !mgmt_req_i.rd && !soft_rst_i ##1 mgmt_req_i.rd
    && mgmt_req_i.addr == ANPR_ADDR_EXPANSION && !soft_rst_i
    |=> mgmt_rdata_o[1])
    else $error("page received lost to a same-cycle read");
endmodule
bind anpr_regs anpr_regs_checker #(.DATA_W(DATA_W)) anpr_regs_checker_inst (
  .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .soft_rst_i(soft_rst_i),
  .mgmt_req_i(mgmt_req_i), .mgmt_rdata_o(mgmt_rdata_o),
  .mgmt_rvalid_o(mgmt_rvalid_o), .page_i(page_i),
  .lp_an_able_i(lp_an_able_i), .pd_fault_i(pd_fault_i),
  .np_sent_i(np_sent_i), .tx_word_o(tx_word_o));

// [anpr_mgmt_master.sv]
// Station management model issuing single-cycle register accesses.
// Assumes tasks are entered just after a rising clock edge.
`timescale 1ns/10ps
module anpr_mgmt_master
  import anpr_pkg::*;
(
  input  wire logic        clk_i,     // Shared clock
  output anpr_mgmt_req_t   req_o,     // Access towards the device
  input  wire logic [15:0] rdata_i,   // Read data
  input  wire logic        rvalid_i   // Read answer pulse
);
  // Idle bus until the first access
  initial req_o = '0;

  // Read with optional idle gap; X back if no answer came
  task automatic rd(input logic [4:0] a, input int gap,
                    output logic [15:0] d);
    repeat (gap) @(posedge clk_i);
    req_o <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
    @(posedge clk_i);
    req_o <= '0;
    @(posedge clk_i);
    d = rvalid_i ? rdata_i : 'x;
  endtask

  // Single-cycle write of any register address, then one idle edge
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    req_o <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
    @(posedge clk_i);
    req_o <= '0;
    // Idle edge so the next access never reassigns req_o in this step
    @(posedge clk_i);
  endtask
endmodule

// [test_anpr_regs.sv]
// Self-checking bench for the page register group.
// Assumes the management model file and checker are compiled with it.
`timescale 1ns/10ps
module test_anpr_regs;
  import anpr_pkg::*;
  logic           ref_clk_i;     // 125 MHz clock
  logic           arst_n_i;      // Async reset, low
  logic           soft_rst_i;    // Software reset pulse
  logic           lp_an_able_i;  // Partner negotiates
  logic           pd_fault_i;    // Parallel detect fault
  logic           np_sent_i;     // Tx page taken
  anpr_mgmt_req_t mgmt_req;      // Access from the model
  anpr_page_t     page;          // Received page strobe
  logic [15:0]    rdata;         // Read data
  logic [15:0]    tx_word;       // Tx code word
  logic [15:0]    got;           // Scratch read value
  logic           rvalid;        // Read answer pulse
  int             errors;        // Mismatch count
  int             n_checks;      // Comparison count

  anpr_regs anpr_regs_inst (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
    .soft_rst_i(soft_rst_i), .mgmt_req_i(mgmt_req), .mgmt_rdata_o(rdata),
    .mgmt_rvalid_o(rvalid), .page_i(page), .lp_an_able_i(lp_an_able_i),
    .pd_fault_i(pd_fault_i), .np_sent_i(np_sent_i), .tx_word_o(tx_word));
  anpr_mgmt_master anpr_mgmt_master_inst (.clk_i(ref_clk_i),
    .req_o(mgmt_req), .rdata_i(rdata), .rvalid_i(rvalid));

  // 8 ns clock
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    anpr_mgmt_master_inst.rd(a, 0, got);
    chk(got, e);
  endtask

  // One-cycle page strobe, whole word
  task automatic send_page(input logic b, input logic [15:0] w);
    page <= '{valid: 1'b1, base: b, word: w};
    @(posedge ref_clk_i);
    page.valid <= 1'b0;
  endtask

  task automatic t_reset;
    rd(ANPR_ADDR_BASE_ABILITY, 16'h0000);
    rd(ANPR_ADDR_EXPANSION, 16'h0004);
    rd(ANPR_ADDR_NP_TRANSMIT, 16'h2001);
    rd(ANPR_ADDR_NP_RECEIVE, 16'h0000);
    rd(5'h1F, 16'h0000);
  endtask

  // Walking one through base pages, walking zero through next pages
  task automatic t_pages;
    logic [15:0] w;
    logic [15:0] f;
    for (int i = 0; i < 16; i++) begin
      w = 16'h0001 << i;
      f = (i == 15) ? 16'h000C : 16'h0004;
      send_page(1'b1, w);
      rd(ANPR_ADDR_EXPANSION, f | 16'h0002);
      rd(ANPR_ADDR_EXPANSION, f);
      rd(ANPR_ADDR_BASE_ABILITY, w & 16'hEFFF);
      send_page(1'b0, ~w);
      rd(ANPR_ADDR_NP_RECEIVE, ~w);
      rd(ANPR_ADDR_BASE_ABILITY, w & 16'hEFFF);
    end
    send_page(1'b1, 16'hFFFF);
    rd(ANPR_ADDR_BASE_ABILITY, 16'hEFFF);
    rd(ANPR_ADDR_EXPANSION, 16'h000E);
    // Page and expansion read in one cycle: the set must win
    fork
      send_page(1'b0, 16'h7FFF);
      rd(ANPR_ADDR_EXPANSION, 16'h000C);
    join
    rd(ANPR_ADDR_EXPANSION, 16'h000E);
  endtask

  // Writes, ignored bits, toggle
  task automatic t_tx;
    anpr_mgmt_master_inst.wr(ANPR_ADDR_NP_TRANSMIT, 16'hFFFF);
    rd(ANPR_ADDR_NP_TRANSMIT, 16'hB7FF);
    chk(tx_word, 16'hB7FF);
    anpr_mgmt_master_inst.wr(ANPR_ADDR_BASE_ABILITY, 16'h1234);
    anpr_mgmt_master_inst.wr(ANPR_ADDR_NP_RECEIVE, 16'h1234);
    anpr_mgmt_master_inst.wr(ANPR_ADDR_EXPANSION, 16'hFFFF);
    rd(ANPR_ADDR_EXPANSION, 16'h000C);
    rd(ANPR_ADDR_BASE_ABILITY, 16'hEFFF);
    rd(ANPR_ADDR_NP_RECEIVE, 16'h7FFF);
    np_sent_i <= 1'b1;
    @(posedge ref_clk_i);
    np_sent_i <= 1'b0;
    @(posedge ref_clk_i);
    chk(tx_word, 16'hBFFF);
    anpr_mgmt_master_inst.wr(ANPR_ADDR_NP_TRANSMIT, 16'h4800);
    rd(ANPR_ADDR_NP_TRANSMIT, 16'h0800);
  endtask

  // Live inputs, then soft and hard resets
  task automatic t_resets;
    lp_an_able_i <= 1'b1;
    pd_fault_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rd(ANPR_ADDR_EXPANSION, 16'h001D);
    soft_rst_i <= 1'b1;
    @(posedge ref_clk_i);
    soft_rst_i <= 1'b0;
    anpr_mgmt_master_inst.rd(ANPR_ADDR_EXPANSION, 2, got);
    chk(got, 16'h0011);
    rd(ANPR_ADDR_NP_TRANSMIT, 16'h2001);
    rd(ANPR_ADDR_BASE_ABILITY, 16'h0000);
    rd(ANPR_ADDR_NP_RECEIVE, 16'h0000);
    lp_an_able_i <= 1'b0;
    pd_fault_i <= 1'b0;
    arst_n_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    rd(ANPR_ADDR_EXPANSION, 16'h0004);
  endtask

  task automatic results;
    if (errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    arst_n_i = 1'b0;
    soft_rst_i = 1'b0;
    lp_an_able_i = 1'b0;
    pd_fault_i = 1'b0;
    np_sent_i = 1'b0;
    page = '0;
    errors = 0;
    n_checks = 0;
    repeat (3) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    t_reset;
    t_pages;
    t_tx;
    t_resets;
    results;
  end

  // Hang guard, far beyond the few hundred cycles needed
  initial begin
    #50000;
    errors++;
    results;
  end
endmodule
